//--- verilog/voice_tx_defs.svh
// register offsets, field positions and reset values of the serial audio transmitter
// assumes an 8-bit register port with 16-bit addresses
`ifndef VOICE_TX_DEFS_SVH
`define VOICE_TX_DEFS_SVH

// register offsets
`define ADDR_IF_CTRL      16'h2528
`define ADDR_MCLK_DIV     16'h252A
`define ADDR_BCLK_DIV     16'h252B
`define ADDR_FRAME_DIV    16'h252C
`define ADDR_TX_MODE      16'h252D
`define ADDR_TX_STAGE     16'h252E
`define ADDR_TX_COMMIT    16'h252F
`define ADDR_CODEC        16'h2530
`define ADDR_RX_MODE      16'h253D
`define ADDR_RX_DATA      16'h253E

// interface control fields
`define CTRL_MASTER_BIT   7
`define CTRL_FRAMING_LSB  5
`define CTRL_WLEN_LSB     3
`define CTRL_SWAP_BIT     2
`define CTRL_FINV_BIT     1
`define CTRL_BINV_BIT     0

// transmit and receive mode fields
`define MODE_MCLK_LOW_BIT 6
`define MODE_FEDGE_BIT    5
`define MODE_FEED_BIT     3
`define MODE_CHAN_LSB     1
`define MODE_CLKON_BIT    0
`define RXMODE_DRAIN_BIT  3

// reset values
`define RST_IF_CTRL       8'hC0
`define RST_DIV           8'h00
`define RST_TX_MODE       8'hFE
`define RST_RX_MODE       8'h00
`define RST_CODEC         8'h00

`endif

//--- verilog/voice_tx_pkg.sv
// types shared by the serial audio transmitter and its helpers
// assumes voice_tx_defs.svh for numeric constants
package voice_tx_pkg;

  // serial framing, in field order
  typedef enum logic [1:0] {
    FMT_I2S,
    FMT_LJ,
    FMT_RJ,
    FMT_DSP
  } frame_format_type;

  // voice codec selection handed to the voice datapath
  typedef enum logic [1:0] {
    CODEC_BYPASS,
    CODEC_ULAW,
    CODEC_ALAW,
    CODEC_ADPCM
  } codec_mode_type;

endpackage

//--- verilog/div_if.sv
// carrier between the transmitter and its tick dividers
// assumes one system clock shared by both ends
`timescale 1ns/1ps
interface div_if #(parameter int W = 9);
  logic         run;          // divider may count
  logic         tick;         // input tick to be divided
  logic [W-1:0] half_period;  // ticks per output pulse, zero stops
  logic         pulse;        // one-cycle output pulse

  modport source  (output run, output tick, output half_period, input pulse);
  modport divider (input run, input tick, input half_period, output pulse);
endinterface

//--- verilog/tick_divider.sv
// counts input ticks and emits one pulse every half_period ticks
// assumes synchronous active-high reset on the shared system clock
`timescale 1ns/1ps
module tick_divider (
  input  wire logic clk_i,        // system clock
  input  wire logic rst_i,        // synchronous reset
  div_if.divider    div           // run, tick, period in; pulse out
);
  logic [8:0] cnt_q;
  logic       pulse_q;
  logic       last_w;

  assign last_w    = (cnt_q + 9'd1) >= div.half_period;
  assign div.pulse = pulse_q;

  // a zero period holds the count and pulse cleared, so the output stays silent
  always_ff @(posedge clk_i) begin
    if (rst_i || !div.run || div.half_period == 9'd0) begin
      cnt_q   <= 9'd0;
      pulse_q <= 1'b0;
    end else if (div.tick) begin
      cnt_q   <= last_w ? 9'd0 : cnt_q + 9'd1;
      pulse_q <= last_w;
    end else begin
      pulse_q <= 1'b0;
    end
  end

  chk_zero_period_silent : assert property (@(posedge clk_i) disable iff (rst_i)
    (div.half_period == 9'd0) |=> !pulse_q)
    else $error("divider pulsed with zero period");
endmodule

//--- verilog/voice_serial_audio_tx.sv
// serial audio transmitter of the voice subsystem with its register file
// assumes synchronous pin inputs, an 8-bit register port and a 25 MHz clk_i
`timescale 1ns/1ps
`include "voice_tx_defs.svh"
module voice_serial_audio_tx (
  input  wire logic                   clk_i,        // system clock
  input  wire logic                   rst_i,        // synchronous reset
  input  wire logic [15:0]            reg_addr_i,   // register address
  input  wire logic [7:0]             reg_wdata_i,  // register write data
  input  wire logic                   reg_wr_i,     // write strobe
  input  wire logic                   reg_rd_i,     // read strobe
  output logic      [7:0]             reg_rdata_o,  // read data, cycle after strobe
  input  wire logic [31:0]            feed_left_i,  // hardware left sample
  input  wire logic [31:0]            feed_right_i, // hardware right sample
  output logic                        feed_take_o,  // samples consumed pulse
  input  wire logic [7:0]             rx_data_i,    // receive data for software
  output logic                        rx_drain_o,   // receive drained by hardware
  output voice_tx_pkg::codec_mode_type codec_mode_o, // codec choice for datapath
  output logic                        mclk_o,       // master clock pin
  output logic                        bclk_o,       // bit clock pin out
  output logic                        bclk_oe_o,    // bit clock driven
  input  wire logic                   bclk_i,       // bit clock pin in
  output logic                        lrck_o,       // frame clock pin out
  output logic                        lrck_oe_o,    // frame clock driven
  input  wire logic                   lrck_i,       // frame clock pin in
  output logic                        sdata_o       // serial data out
);
  import voice_tx_pkg::*;

  logic [7:0]  ctrl_q, mdiv_q, bdiv_q, fdiv_q, txmode_q, rxmode_q, codec_q, rdata_q;
  logic [31:0] stage_q, left_q, right_q, cur_l_q, cur_r_q;
  logic        mclk_q, mclk_pin_q, bclk_q, bclk_pin_q, lrck_q, sdata_q, take_q;
  logic        bsync1_q, bsync2_q, bsync3_q, lsync1_q, lsync2_q, lsync3_q, pend_q;
  logic [9:0]  pos_q, pos_d;
  logic        mclk_d, bclk_d;

  div_if #(.W(9)) mdiv_if ();
  div_if #(.W(9)) bdiv_if ();

  // configuration fields
  frame_format_type framing;
  logic       master_on, swap_on, frame_inv, bclk_inv;
  logic       mclk_low, edge_rise, feed_on, clk_on;
  logic [1:0] wlen_sel, chan_mode;
  logic [9:0] wbits, fdiv10, frame_len;
  assign master_on = ctrl_q[`CTRL_MASTER_BIT];
  assign framing   = frame_format_type'(ctrl_q[`CTRL_FRAMING_LSB +: 2]);
  assign wlen_sel  = ctrl_q[`CTRL_WLEN_LSB +: 2];
  assign swap_on   = ctrl_q[`CTRL_SWAP_BIT];
  assign frame_inv = ctrl_q[`CTRL_FINV_BIT];
  assign bclk_inv  = ctrl_q[`CTRL_BINV_BIT];
  assign mclk_low  = txmode_q[`MODE_MCLK_LOW_BIT];
  assign edge_rise = txmode_q[`MODE_FEDGE_BIT];
  assign feed_on   = txmode_q[`MODE_FEED_BIT];
  assign chan_mode = txmode_q[`MODE_CHAN_LSB +: 2];
  assign clk_on    = txmode_q[`MODE_CLKON_BIT];
  assign wbits     = word_bits(wlen_sel);
  assign fdiv10    = {2'b00, fdiv_q};
  assign frame_len = (framing == FMT_DSP) ? fdiv10 : {1'b0, fdiv_q, 1'b0};

  function automatic logic [9:0] word_bits(input logic [1:0] sel);
    case (sel)
      2'h0:    word_bits = 10'd16;
      2'h1:    word_bits = 10'd20;
      2'h2:    word_bits = 10'd24;
      default: word_bits = 10'd32;
    endcase
  endfunction

  // bit k of a word counted from its MSB; the word sits in the low wbits bits
  function automatic logic pick(input logic [31:0] s, input logic [9:0] k);
    logic [9:0] idx;
    idx  = wbits - 10'd1 - k;
    pick = s[idx[4:0]];
  endfunction

  // serial bit for frame position p; I2S runs one bit behind its frame edge
  function automatic logic data_bit(input logic [9:0] p);
    logic [9:0] q, b, k;
    logic       slot, right, ok;
    q = p;
    b = 10'd0;
    k = 10'd0;
    slot = 1'b0;
    ok = 1'b0;
    if (framing == FMT_I2S) q = (p == 10'd0) ? frame_len - 10'd1 : p - 10'd1;
    if (framing == FMT_DSP) begin
      slot = q > wbits;
      ok   = (q != 10'd0) && (q <= {wbits[8:0], 1'b0});
      k    = slot ? q - 10'd1 - wbits : q - 10'd1;
    end else begin
      slot = q >= fdiv10;
      b    = slot ? q - fdiv10 : q;
      if (framing == FMT_RJ) begin
        ok = (b + wbits) >= fdiv10;
        k  = b + wbits - fdiv10;
      end else begin
        ok = b < wbits;
        k  = b;
      end
    end
    right = slot ^ swap_on;
    ok    = ok && (right ? chan_mode[0] : chan_mode[1]);
    data_bit = ok && (right ? pick(cur_r_q, k) : pick(cur_l_q, k));
  endfunction

  // frame clock level for position p with the frame_inv polarity applied
  function automatic logic lr_level(input logic [9:0] p);
    logic lvl;
    case (framing)
      FMT_I2S: lvl = p >= fdiv10;
      FMT_DSP: lvl = p == 10'd0;
      default: lvl = p < fdiv10;
    endcase
    lr_level = lvl ^ frame_inv;
  endfunction

  // clock dividers: MCLK from clk_i, BCLK from MCLK half periods
  assign mdiv_if.run         = clk_on && (mdiv_q != 8'h00);
  assign mdiv_if.tick        = 1'b1;
  assign mdiv_if.half_period = {1'b0, mdiv_q};
  assign bdiv_if.run         = mdiv_if.run && master_on && (bdiv_q != 8'h00);
  assign bdiv_if.tick        = mdiv_if.pulse;
  assign bdiv_if.half_period = (mdiv_q == 8'h01) ? {1'b0, bdiv_q} : {bdiv_q, 1'b0};

  tick_divider u_mclk_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .div   (mdiv_if.divider)
  );

  tick_divider u_bclk_div (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .div   (bdiv_if.divider)
  );

  // clock levels before the pin polarity is applied
  assign mclk_d = !mdiv_if.run ? 1'b0 : (mdiv_if.pulse ? !mclk_q : mclk_q);
  assign bclk_d = !bdiv_if.run ? 1'b0 : (bdiv_if.pulse ? !bclk_q : bclk_q);

  // edge events: own divider in master mode, synchronised pins in slave mode
  logic frame_on, rise_m, fall_m, rise_s, fall_s, rise_ev, fall_ev;
  logic bint_new, bint_old, lint_new, lint_old, lrck_start, start_now;
  assign frame_on   = clk_on && (fdiv_q != 8'h00);
  assign rise_m     = bdiv_if.pulse && !bclk_q;
  assign fall_m     = bdiv_if.pulse && bclk_q;
  assign bint_new   = bsync2_q ^ bclk_inv;
  assign bint_old   = bsync3_q ^ bclk_inv;
  assign rise_s     = bint_new && !bint_old;
  assign fall_s     = !bint_new && bint_old;
  assign rise_ev    = frame_on && (master_on ? rise_m : rise_s);
  assign fall_ev    = frame_on && (master_on ? fall_m : fall_s);
  assign lint_new   = lsync2_q ^ frame_inv;
  assign lint_old   = lsync3_q ^ frame_inv;
  assign lrck_start = !master_on && (lint_new != lint_old) && (lint_new == (framing != FMT_I2S));
  assign start_now  = lrck_start || pend_q;

  // frame position advances on internal falling bit clock edges
  logic pos_wrap, load_ev;
  assign pos_wrap = (pos_q >= frame_len - 10'd1) || (!master_on && start_now);
  assign pos_d    = !frame_on ? 10'd0 : (fall_ev ? (pos_wrap ? 10'd0 : pos_q + 10'd1) : pos_q);
  assign load_ev  = fall_ev && (pos_d == 10'd0);

  // sample source: software registers or the voice datapath
  logic [31:0] src_l, src_r;
  assign src_l = feed_on ? feed_left_i : left_q;
  assign src_r = feed_on ? feed_right_i : right_q;

  // external clocks pass two flops before any edge logic reads them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {bsync1_q, bsync2_q, bsync3_q} <= 3'h0;
      {lsync1_q, lsync2_q, lsync3_q} <= 3'h0;
    end else begin
      {bsync1_q, bsync2_q, bsync3_q} <= {bclk_i, bsync1_q, bsync2_q};
      {lsync1_q, lsync2_q, lsync3_q} <= {lrck_i, lsync1_q, lsync2_q};
    end
  end

  // clock pins; polarity applied on the next level so pins have no extra lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_q     <= 1'b0;
      bclk_q     <= 1'b0;
      mclk_pin_q <= 1'b0;
      bclk_pin_q <= 1'b0;
    end else begin
      mclk_q     <= mclk_d;
      bclk_q     <= bclk_d;
      mclk_pin_q <= mclk_d ^ !mclk_low;
      bclk_pin_q <= bclk_d ^ bclk_inv;
    end
  end

  // frame engine: position, frame clock, serial data and pending slave start
  always_ff @(posedge clk_i) begin
    if (rst_i || !frame_on) begin
      pos_q   <= 10'd0;
      lrck_q  <= 1'b0;
      sdata_q <= 1'b0;
      pend_q  <= 1'b0;
    end else begin
      pos_q  <= pos_d;
      pend_q <= (lrck_start || pend_q) && !fall_ev;   // a start that meets a falling edge is used at once
      if (fall_ev && !edge_rise) lrck_q <= lr_level(pos_d);
      if (rise_ev && edge_rise) lrck_q <= lr_level(pos_q);
      if (fall_ev && framing == FMT_I2S) sdata_q <= data_bit(pos_d);
      if (rise_ev && framing != FMT_I2S) sdata_q <= data_bit(pos_q);
    end
  end

  // current frame samples are swapped in at each frame start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_l_q <= 32'h0;
      cur_r_q <= 32'h0;
      take_q  <= 1'b0;
    end else begin
      take_q <= load_ev && feed_on;
      if (load_ev) begin
        cur_l_q <= src_l;
        cur_r_q <= src_r;
      end
    end
  end

  // register writes; the stage register collects a sample a byte at a time
  logic wr_ctrl, wr_commit;
  assign wr_ctrl   = reg_wr_i && (reg_addr_i == `ADDR_IF_CTRL);
  assign wr_commit = reg_wr_i && (reg_addr_i == `ADDR_TX_COMMIT);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `RST_IF_CTRL;
      mdiv_q   <= `RST_DIV;
      bdiv_q   <= `RST_DIV;
      fdiv_q   <= `RST_DIV;
      txmode_q <= `RST_TX_MODE;
      rxmode_q <= `RST_RX_MODE;
      codec_q  <= `RST_CODEC;
    end else if (reg_wr_i) begin
      if (wr_ctrl) ctrl_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_MCLK_DIV) mdiv_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_BCLK_DIV) bdiv_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_FRAME_DIV) fdiv_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_TX_MODE) txmode_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_RX_MODE) rxmode_q <= reg_wdata_i;
      if (reg_addr_i == `ADDR_CODEC) codec_q <= reg_wdata_i;
    end
  end

  // software sample path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_q <= 32'h0;
      left_q  <= 32'h0;
      right_q <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ADDR_TX_STAGE) stage_q <= {stage_q[23:0], reg_wdata_i};
      if (wr_commit && !reg_wdata_i[0]) left_q <= stage_q;
      if (wr_commit && reg_wdata_i[0]) right_q <= stage_q;
    end
  end

  // read selection; unmapped addresses read zero
  logic [7:0] status_w, rd_mux;
  assign status_w = {5'h00, lrck_q, master_on, frame_on};
  assign rd_mux =
    (reg_addr_i == `ADDR_IF_CTRL)   ? ctrl_q   :
    (reg_addr_i == `ADDR_MCLK_DIV)  ? mdiv_q   :
    (reg_addr_i == `ADDR_BCLK_DIV)  ? bdiv_q   :
    (reg_addr_i == `ADDR_FRAME_DIV) ? fdiv_q   :
    (reg_addr_i == `ADDR_TX_MODE)   ? txmode_q :
    (reg_addr_i == `ADDR_TX_COMMIT) ? status_w :
    (reg_addr_i == `ADDR_CODEC)     ? codec_q  :
    (reg_addr_i == `ADDR_RX_MODE)   ? rxmode_q :
    (reg_addr_i == `ADDR_RX_DATA)   ? rx_data_i : 8'h00;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_q <= 8'h00;
    else rdata_q <= reg_rd_i ? rd_mux : 8'h00;
  end

  // outputs straight from flops; bit and frame clock pins are driven only as master
  assign reg_rdata_o  = rdata_q;
  assign feed_take_o  = take_q;
  assign rx_drain_o   = rxmode_q[`RXMODE_DRAIN_BIT];
  assign codec_mode_o = codec_mode_type'(codec_q[1:0]);
  assign mclk_o       = mclk_pin_q;
  assign bclk_o       = bclk_pin_q;
  assign bclk_oe_o    = ctrl_q[`CTRL_MASTER_BIT];
  assign lrck_o       = lrck_q;
  assign lrck_oe_o    = ctrl_q[`CTRL_MASTER_BIT];
  assign sdata_o      = sdata_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_dsp_sync_bit;
    framing == FMT_DSP && fall_ev && !edge_rise && pos_d == 10'd0;
  endsequence

  sequence s_dsp_next_fall;
    fall_ev && !edge_rise && pos_d != 10'd0 && framing == FMT_DSP;
  endsequence

  chk_ctrl_reset_value : assert property ($past(rst_i) |-> ctrl_q == `RST_IF_CTRL)
    else $error("control register reset value wrong");
  chk_mclk_stops_zero : assert property (mdiv_q == 8'h00 && $past(mdiv_q) == 8'h00 && $stable(mclk_low)
    |=> $stable(mclk_o))
    else $error("mclk moved with zero divisor");
  chk_mclk_half_period : assert property (mdiv_q >= 8'h02 && mdiv_if.pulse |=> !mdiv_if.pulse)
    else $error("mclk half period too short");
  chk_bclk_stops_zero : assert property (bdiv_q == 8'h00 && $past(bdiv_q) == 8'h00
    |-> !bdiv_if.pulse ##1 bclk_q == 1'b0)
    else $error("bclk ran with zero divisor");
  chk_frame_zero_idle : assert property (fdiv_q == 8'h00 |=> pos_q == 10'd0 && sdata_o == 1'b0)
    else $error("frame ran with zero divisor");
  chk_idle_when_off : assert property (!clk_on |=> !mclk_q && !bclk_q && !sdata_o && !lrck_o)
    else $error("interface active while disabled");
  chk_dsp_sync_pulse : assert property (s_dsp_sync_bit |=> lrck_q == !frame_inv)
    else $error("dsp sync pulse missing");
  chk_dsp_sync_ends : assert property (s_dsp_next_fall |=> lrck_q == frame_inv)
    else $error("dsp sync pulse longer than one bit");
  chk_lj_data_rise : assert property (framing != FMT_I2S && $stable(ctrl_q) && $past(frame_on) && frame_on
    && $changed(sdata_o) |-> $past(rise_ev))
    else $error("data changed off the rising edge");
  chk_i2s_data_fall : assert property (framing == FMT_I2S && $stable(ctrl_q) && $past(frame_on) && frame_on
    && $changed(sdata_o) |-> $past(fall_ev))
    else $error("i2s data changed off the falling edge");
endmodule

//--- verif/audio_dac_model.sv
// receiving audio converter: recovers the two channel words from the serial link
// assumes pins updated on clk_i and a non-inverted bit clock, 16-bit words
`timescale 1ns/1ps
module audio_dac_model (
  input  wire logic                           clk_i,     // system clock
  input  wire logic                           bclk_i,    // bit clock pin
  input  wire logic                           lrck_i,    // frame clock pin
  input  wire logic                           sdata_i,   // serial data pin
  input  wire voice_tx_pkg::frame_format_type fmt_i,     // framing in use
  input  wire logic [4:0]                     slot_i,    // bits per slot
  output logic      [15:0]                    word_lo_o, // word carried at frame clock low
  output logic      [15:0]                    word_hi_o, // word carried at frame clock high
  output logic      [7:0]                     words_o    // words received
);
  import voice_tx_pkg::*;
  logic        b_q = 1'b0;
  logic        l_q = 1'b0;
  logic        l_w = 1'b0;
  logic [31:0] sr  = 32'h0000_0000;
  initial begin
    word_lo_o = 16'h0000;
    word_hi_o = 16'h0000;
    words_o   = 8'h00;
  end
  // sample data on the edge away from its change; frame clock taken as held just before
  // that edge, so a frame clock moving on the same edge cannot race the sample
  always @(posedge clk_i) begin : rx
    logic [31:0] snap;
    logic [15:0] w;
    snap = {sr[30:0], sdata_i};
    w = 16'(snap >> ((fmt_i == FMT_I2S) ? slot_i - 5'h10 : (fmt_i == FMT_LJ) ? slot_i - 5'h0F : 5'h01));
    if ((fmt_i == FMT_I2S) ? (!b_q && bclk_i) : (b_q && !bclk_i)) begin
      sr  <= snap;
      l_w <= l_q;
      if (l_q != l_w) begin
        if (l_w)
          word_hi_o <= w;
        else
          word_lo_o <= w;
        words_o <= words_o + 8'h01;
      end
    end
    b_q <= bclk_i;
    l_q <= lrck_i;
  end
endmodule

//--- verif/voice_serial_audio_tx_bench.sv
// self-checking bench for the serial audio transmitter
// assumes the design files compile first; slave clock pins are driven only by the slave scenario
`timescale 1ns/1ps
`include "voice_tx_defs.svh"
module voice_serial_audio_tx_bench;
  import voice_tx_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, sbclk = 1'b0, slrck = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000, word_lo, word_hi;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, words;
  logic [31:0] feed_left_i = 32'h0000_0000, feed_right_i = 32'h0000_0000;
  logic feed_take_o, rx_drain_o, mclk_o, bclk_o, bclk_oe_o, lrck_o, lrck_oe_o, sdata_o;
  codec_mode_type codec_mode_o;
  frame_format_type fmt = FMT_I2S;
  logic [4:0] slot = 5'h10;
  int error_cnt = 0, num_checks = 0;

  voice_serial_audio_tx DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .feed_left_i(feed_left_i), .feed_right_i(feed_right_i), .feed_take_o(feed_take_o),
    .rx_data_i(8'h5A), .rx_drain_o(rx_drain_o), .codec_mode_o(codec_mode_o), .mclk_o(mclk_o),
    .bclk_o(bclk_o), .bclk_oe_o(bclk_oe_o), .bclk_i(sbclk), .lrck_o(lrck_o),
    .lrck_oe_o(lrck_oe_o), .lrck_i(slrck), .sdata_o(sdata_o));
  // the converter listens to whichever side drives the clock pins
  audio_dac_model dac (.clk_i(clk_i), .bclk_i(bclk_oe_o ? bclk_o : sbclk),
    .lrck_i(lrck_oe_o ? lrck_o : slrck), .sdata_i(sdata_o),
    .fmt_i(fmt), .slot_i(slot), .word_lo_o(word_lo), .word_hi_o(word_hi), .words_o(words));

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  task automatic finish_test();
    $display("Checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one-cycle strobes; a spare edge keeps a strobe from being driven twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, exp}, "register read");
    @(posedge clk_i);
    #1;
  endtask

  task automatic put(input logic [15:0] v, input logic right);
    wr(`ADDR_TX_STAGE, v[15:8]);
    wr(`ADDR_TX_STAGE, v[7:0]);
    wr(`ADDR_TX_COMMIT, {7'h00, right});
  endtask

  // bounded wait for the converter to see n more channel words
  task automatic wait_words(input logic [7:0] n);
    logic [7:0] start;
    start = words;
    for (int i = 0; i < 4000 && 8'(words - start) < n; i++)
      @(posedge clk_i);
    #1;
    if (8'(words - start) < n) begin
      error_cnt++;
      $display("Error at %0t: converter saw too few words", $time);
    end
  endtask

  // program framing, let stale frames flush, then judge both slots
  task automatic frame(input frame_format_type f, input logic sw, input logic fi,
                       input logic [4:0] s, input logic [15:0] l, input logic [15:0] r);
    logic lvl;
    fmt <= f;
    slot <= s;
    wr(`ADDR_FRAME_DIV, {3'h0, s});
    wr(`ADDR_IF_CTRL, {1'b1, f, 2'b00, sw, fi, 1'b0});
    wait_words(8'h06);
    lvl = (f != FMT_I2S) ^ fi;
    chk(lvl ? word_hi : word_lo, sw ? r : l, "first slot word");
    chk(lvl ? word_lo : word_hi, sw ? l : r, "second slot word");
  endtask

  task automatic t_reset();
    rd(`ADDR_IF_CTRL, 8'hC0);
    rd(`ADDR_TX_MODE, 8'hFE);
    rd(`ADDR_RX_MODE, 8'h00);
    rd(`ADDR_MCLK_DIV, 8'h00);
    rd(16'h2600, 8'h00);
    chk({14'h0, bclk_oe_o, lrck_oe_o}, 16'h0003, "master pins driven");
  endtask

  task automatic t_frames();
    wr(`ADDR_MCLK_DIV, 8'h01);
    wr(`ADDR_BCLK_DIV, 8'h01);
    put(16'hA5C3, 1'b0);
    put(16'h3C5A, 1'b1);
    wr(`ADDR_TX_MODE, 8'h47);
    frame(FMT_I2S, 1'b0, 1'b0, 5'h10, 16'hA5C3, 16'h3C5A);
    frame(FMT_LJ, 1'b0, 1'b0, 5'h14, 16'hA5C3, 16'h3C5A);
    frame(FMT_RJ, 1'b0, 1'b0, 5'h14, 16'hA5C3, 16'h3C5A);
    frame(FMT_LJ, 1'b0, 1'b1, 5'h14, 16'hA5C3, 16'h3C5A);
    frame(FMT_I2S, 1'b1, 1'b0, 5'h10, 16'hA5C3, 16'h3C5A);
    wr(`ADDR_TX_MODE, 8'h67);
    frame(FMT_LJ, 1'b0, 1'b0, 5'h14, 16'hA5C3, 16'h3C5A);
  endtask

  // hardware feed: upper sample bits differ so a wrong slice shows up
  task automatic t_feed();
    feed_left_i <= 32'hFFFF_1234;
    feed_right_i <= 32'h0000_8E71;
    wr(`ADDR_TX_MODE, 8'h4F);
    for (int i = 0; i < 1000 && feed_take_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk({15'h0, feed_take_o}, 16'h0001, "feed take pulse");
    frame(FMT_I2S, 1'b0, 1'b0, 5'h10, 16'h1234, 16'h8E71);
  endtask

  task automatic t_misc();
    logic [15:0] cnt;
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CODEC, 8'(i));
      chk({14'h0, codec_mode_o}, 16'(i), "codec mode");
    end
    rd(`ADDR_RX_DATA, 8'h5A);
    wr(`ADDR_RX_MODE, 8'h08);
    chk({15'h0, rx_drain_o}, 16'h0001, "drain enable");
    for (int d = 3; d >= 0; d -= 3) begin
      wr(`ADDR_MCLK_DIV, 8'(d));
      cnt = 16'h0000;
      repeat (12) @(posedge clk_i);
      repeat (120) begin
        @(posedge clk_i);
        #1;
        cnt = cnt + {15'h0, mclk_o};
      end
      chk(cnt, (d == 3) ? 16'd60 : 16'd0, "master clock high cycles");
    end
    wr(`ADDR_TX_MODE, 8'h46);
    repeat (8) @(posedge clk_i);
    #1;
    chk({14'h0, lrck_o, sdata_o}, 16'h0000, "idle link");
    wr(`ADDR_IF_CTRL, 8'h41);
    chk({14'h0, bclk_oe_o, lrck_oe_o}, 16'h0000, "slave pins released");
    chk({15'h0, bclk_o}, 16'h0001, "inverted idle bit clock");
  endtask

  // dsp: frame of 33 bits, sync high one bit period, two system clocks at these divisors
  task automatic t_dsp();
    logic [15:0] hi;
    wr(`ADDR_FRAME_DIV, 8'h21);
    wr(`ADDR_IF_CTRL, 8'hE0);
    repeat (200) @(posedge clk_i);
    hi = 16'h0000;
    repeat (660) begin
      @(posedge clk_i);
      #1;
      hi = hi + {15'h0, lrck_o};
    end
    chk(hi, 16'h0014, "dsp sync width");
  endtask

  // slave: eight system clocks per bit, frame clock falls at the left word; converter keeps I2S, 16 bits
  task automatic t_slave();
    wr(`ADDR_IF_CTRL, 8'h00);
    wr(`ADDR_FRAME_DIV, 8'h10);
    for (int n = 0; n < 1280; n++) begin
      @(posedge clk_i);
      sbclk <= n[2];
      slrck <= n[7];
    end
    #1;
    chk(word_lo, 16'h1234, "slave left word");
    chk(word_hi, 16'h8E71, "slave right word");
  endtask

  // main sequence: two-cycle reset, then the scenarios in turn
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    t_reset();
    t_frames();
    t_feed();
    t_dsp();
    t_slave();
    t_misc();
    finish_test();
  end

  // watchdog well beyond the few thousand cycles the scenarios need
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
endmodule
